// ### rtl/drive_input_regs.vh
// Register map, field positions and timing constants of the input decoder
`ifndef DRIVE_INPUT_REGS_VH
`define DRIVE_INPUT_REGS_VH
`define CTRL_ADDR 6'h00
`define ASSIGN0_ADDR 6'h04
`define ASSIGN1_ADDR 6'h08
`define TIMER_ON_ADDR 6'h0C
`define TIMER_OFF_ADDR 6'h10
`define PGAIN_ADDR 6'h14
`define IGAIN_ADDR 6'h18
`define LPF_ADDR 6'h1C
`define RAMP_ADDR 6'h20
`define FLUX_ADDR 6'h24
`define STATUS_ADDR 6'h28
`define INT_STATUS_ADDR 6'h2C
`define INT_MASK_ADDR 6'h30
`define CMD_ADDR 6'h34
`define CTRL_THREE_WIRE 0
`define CTRL_PID_LO 1
`define CTRL_PID_HI 2
`define PID_DISABLE 2'h0
`define PID_ENABLE 2'h1
`define PID_TERMINAL 2'h2
`define FN_STOP3W 0
`define FN_TRIPB 1
`define FN_FWD_BLOCK 2
`define FN_REV_BLOCK 3
`define FN_PID_DIS 4
`define FN_TIMER_IN 5
`define FN_XCEL_LO 6
`define FN_XCEL_HI 7
`define FN_RAMP_BYPASS 8
`define FN_GAIN_SEL 9
`define FN_STRUCT_SEL 10
`define FN_FLUX_SEL 11
`define INT_TRIP 0
`define INT_TIMER 1
`define INT_GAIN 2
`define CMD_TRIP_RESET 0
`define TIMER_RESET 16'h000A
`define PGAIN_MAX 11'h7D0
`define CLK_PERIOD_NS 100
`define TIMER_STEP_NS 100000000
`define BLINK_BIT 21
`define FILTER_COUNT 2'h3
`define RAMP_CYCLES_PER_MS_LSB 5
`define FLUX_SCALE 11'h3E8
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ### rtl/drive_input_function_logic.v
// Multi-function input terminal decoder with AXI4-Lite register slave
//
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "drive_input_regs.vh"

// Behaviour
// - Three-wire mode latches momentary run pulses
// - Tripb input off stops power switch gating
// - Trip shows message, blinks stop lamp, latches
// - Forward block zeroes positive speed command
// - Three-valued PID enable, disable blocks output
// - Terminal mode: assigned, input off, running
// - Enable mode: PID runs only while running
// - Disabled process controller output forced zero
// - Timer output with on and off delays
// - Two select inputs pick accel set
// - Ramp bypass overrides set select, shortest ramp
// - Gain select chooses speed loop set
// - Structure select picks P or PI
// - Proportional gain ramps to new set
// - Flux select takes scaled bipolar analog
module drive_input_function_logic #(
  parameter TENTH_SEC_CYCLES = `TIMER_STEP_NS / `CLK_PERIOD_NS
) (
  // Clock and reset
  input wire i_ref_clk,
  input wire i_rst,
  // AXI4-Lite slave
  input wire [5:0] i_awaddr,
  input wire i_awvalid,
  output wire o_awready,
  input wire [31:0] i_wdata,
  input wire [3:0] i_wstrb,
  input wire i_wvalid,
  output wire o_wready,
  output wire [1:0] o_bresp,
  output wire o_bvalid,
  input wire i_bready,
  input wire [5:0] i_araddr,
  input wire i_arvalid,
  output wire o_arready,
  output wire [31:0] o_rdata,
  output wire [1:0] o_rresp,
  output wire o_rvalid,
  input wire i_rready,
  // Terminals
  input wire i_forward_run_input,
  input wire i_reverse_run_input,
  input wire [6:0] i_terminal,
  // Controller data
  input wire [15:0] i_speed_cmd,
  input wire [15:0] i_pid_out,
  input wire [11:0] i_analog_in,
  // Drive outputs
  output wire o_run_forward,
  output wire o_run_reverse,
  output wire o_gate_enable,
  output wire o_trip_message,
  output wire o_stop_led_blink,
  output wire [15:0] o_speed_cmd,
  output wire o_pid_enable,
  output wire [15:0] o_pid_out,
  output wire o_aux_output_one,
  output wire [1:0] o_accel_set,
  output wire o_ramp_bypass,
  output wire [10:0] o_gain_p,
  output wire [15:0] o_gain_i,
  output wire [15:0] o_gain_lpf,
  output wire o_gain_set,
  output wire o_integral_en,
  output wire o_flux_from_analog,
  output wire [15:0] o_flux_ref,
  output wire o_irq
);

  localparam [31:0] TICK_SPAN = TENTH_SEC_CYCLES - 1;
  localparam [19:0] TICK_LAST = TICK_SPAN[19:0];

  reg [2:0] ctrl_reg;
  reg [23:0] assign0_reg;
  reg [11:0] assign1_reg;
  reg [15:0] timer_on_reg;
  reg [15:0] timer_off_reg;
  reg [21:0] pgain_reg;
  reg [31:0] igain_reg;
  reg [31:0] lpf_reg;
  reg [15:0] ramp_reg;
  reg [15:0] flux_reg;
  reg [2:0] int_status_reg;
  reg [2:0] int_mask_reg;
  reg [5:0] awaddr_reg;
  reg aw_held_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  reg w_held_reg;
  reg bvalid_reg;
  reg [1:0] bresp_reg;
  reg rvalid_reg;
  reg [31:0] rdata_reg;
  reg [1:0] rresp_reg;
  wire [8:0] filt_reg;
  reg fwd_latch_reg;
  reg rev_latch_reg;
  reg fx_prev_reg;
  reg rx_prev_reg;
  reg trip_reg;
  reg [21:0] blink_reg;
  reg [15:0] speed_reg;
  reg [15:0] pid_reg;
  reg [19:0] tick_reg;
  reg [15:0] timer_cnt_reg;
  reg timer_out_reg;
  reg [10:0] gain_p_reg;
  reg [20:0] ramp_cnt_reg;
  reg gain_set_prev_reg;
  reg [15:0] flux_out_reg;

  wire [8:0] raw_in;
  wire [7:0] term_vec;
  wire [35:0] fmap;
  wire do_write;
  wire trip_reset;
  wire tick;
  wire run_cmd;
  wire tripb_on;
  wire fwd_block;
  wire rev_block;
  wire pid_en;
  wire timer_in;
  wire gain_set;
  wire [10:0] gain_target;
  wire [20:0] ramp_step;
  wire [31:0] ramp_full;
  wire [31:0] wr_word;
  wire [15:0] on_delay;
  wire [15:0] off_delay;
  wire [2:0] events;
  wire [26:0] flux_prod;
  wire [31:0] status_word;

  // Byte-lane merge for register writes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          merge[b*8 +: 8] = data[b*8 +: 8];
        end
      end
    end
  endfunction

  // Terminal index lookup, zero means not assigned
  function fval;
    input [2:0] idx;
    input [7:0] vec;
    begin
      fval = vec[idx];
    end
  endfunction

  // Register word at a word index, zero where unmapped
  function [31:0] word_at;
    input [3:0] idx;
    begin
      case (idx)
        `CTRL_ADDR >> 2: word_at = {29'h0, ctrl_reg};
        `ASSIGN0_ADDR >> 2: word_at = {8'h0, assign0_reg};
        `ASSIGN1_ADDR >> 2: word_at = {20'h0, assign1_reg};
        `TIMER_ON_ADDR >> 2: word_at = {16'h0, timer_on_reg};
        `TIMER_OFF_ADDR >> 2: word_at = {16'h0, timer_off_reg};
        `PGAIN_ADDR >> 2: word_at = {10'h0, pgain_reg};
        `IGAIN_ADDR >> 2: word_at = igain_reg;
        `LPF_ADDR >> 2: word_at = lpf_reg;
        `RAMP_ADDR >> 2: word_at = {16'h0, ramp_reg};
        `FLUX_ADDR >> 2: word_at = {16'h0, flux_reg};
        `STATUS_ADDR >> 2: word_at = status_word;
        `INT_STATUS_ADDR >> 2: word_at = {29'h0, int_status_reg};
        `INT_MASK_ADDR >> 2: word_at = {29'h0, int_mask_reg};
        default: word_at = 32'h00000000;
      endcase
    end
  endfunction

  // Input sampling and noise filter
  assign raw_in = {i_terminal, i_reverse_run_input, i_forward_run_input};
  genvar g;
  generate
    for (g = 0; g < 9; g = g + 1) begin : filt_gen
      reg smp_reg;
      reg [1:0] cnt_reg;
      reg flt_reg;
      assign filt_reg[g] = flt_reg;
      always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
          smp_reg <= 1'b0;
          cnt_reg <= 2'h0;
          flt_reg <= 1'b0;
        end else begin
          smp_reg <= raw_in[g];
          if (smp_reg == flt_reg) begin
            cnt_reg <= 2'h0;
          end else if (cnt_reg == `FILTER_COUNT) begin
            cnt_reg <= 2'h0;
            flt_reg <= smp_reg;
          end else begin
            cnt_reg <= cnt_reg + 2'h1;
          end
        end
      end
    end
  endgenerate

  assign term_vec = {filt_reg[8:2], 1'b0};
  assign fmap = {assign1_reg, assign0_reg};
  assign tripb_on = (fmap[`FN_TRIPB*3 +: 3] != 3'h0) &&
                    !fval(fmap[`FN_TRIPB*3 +: 3], term_vec);
  assign fwd_block = fval(fmap[`FN_FWD_BLOCK*3 +: 3], term_vec);
  assign rev_block = fval(fmap[`FN_REV_BLOCK*3 +: 3], term_vec);
  assign timer_in = fval(fmap[`FN_TIMER_IN*3 +: 3], term_vec);
  assign gain_set = fval(fmap[`FN_GAIN_SEL*3 +: 3], term_vec);

  // AXI4-Lite write channel
  assign o_awready = !aw_held_reg && !bvalid_reg;
  assign o_wready = !w_held_reg && !bvalid_reg;
  assign o_bvalid = bvalid_reg;
  assign o_bresp = bresp_reg;
  assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wr_word = merge(word_at(awaddr_reg[5:2]), wdata_reg, wstrb_reg);
  assign trip_reset = do_write && (awaddr_reg[5:2] == `CMD_ADDR >> 2) &&
                      wstrb_reg[0] && wdata_reg[`CMD_TRIP_RESET];

  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 6'h00;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
      ctrl_reg <= 3'h0;
      assign0_reg <= 24'h000000;
      assign1_reg <= 12'h000;
      timer_on_reg <= `TIMER_RESET;
      timer_off_reg <= `TIMER_RESET;
      pgain_reg <= 22'h000000;
      igain_reg <= 32'h00000000;
      lpf_reg <= 32'h00000000;
      ramp_reg <= 16'h0000;
      flux_reg <= 16'h0000;
      int_mask_reg <= 3'h0;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= i_wdata;
        wstrb_reg <= i_wstrb;
      end
      if (bvalid_reg && i_bready) begin
        bvalid_reg <= 1'b0;
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= `RESP_OKAY;
        case (awaddr_reg[5:2])
          `CTRL_ADDR >> 2: ctrl_reg <= wr_word[2:0];
          `ASSIGN0_ADDR >> 2: assign0_reg <= wr_word[23:0];
          `ASSIGN1_ADDR >> 2: assign1_reg <= wr_word[11:0];
          `TIMER_ON_ADDR >> 2: timer_on_reg <= wr_word[15:0];
          `TIMER_OFF_ADDR >> 2: timer_off_reg <= wr_word[15:0];
          `PGAIN_ADDR >> 2: pgain_reg <= wr_word[21:0];
          `IGAIN_ADDR >> 2: igain_reg <= wr_word;
          `LPF_ADDR >> 2: lpf_reg <= wr_word;
          `RAMP_ADDR >> 2: ramp_reg <= wr_word[15:0];
          `FLUX_ADDR >> 2: flux_reg <= wr_word[15:0];
          `INT_MASK_ADDR >> 2: int_mask_reg <= wr_word[2:0];
          `STATUS_ADDR >> 2, `INT_STATUS_ADDR >> 2, `CMD_ADDR >> 2: begin
            bresp_reg <= `RESP_OKAY;
          end
          default: begin
            bresp_reg <= `RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // AXI4-Lite read channel
  assign o_arready = !rvalid_reg;
  assign o_rvalid = rvalid_reg;
  assign o_rdata = rdata_reg;
  assign o_rresp = rresp_reg;
  assign status_word = {11'h0, filt_reg, gain_set, o_accel_set,
                        o_pid_enable, timer_out_reg, trip_reg,
                        rev_latch_reg, fwd_latch_reg, run_cmd,
                        o_ramp_bypass, o_integral_en, o_flux_from_analog};

  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= `RESP_OKAY;
    end else if (rvalid_reg) begin
      if (i_rready) begin
        rvalid_reg <= 1'b0;
      end
    end else if (i_arvalid) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= word_at(i_araddr[5:2]);
      if (i_araddr[5:2] > (`CMD_ADDR >> 2)) begin
        rresp_reg <= `RESP_SLVERR;
      end else begin
        rresp_reg <= `RESP_OKAY;
      end
    end
  end

  // Run command latch and external trip
  assign run_cmd = ctrl_reg[`CTRL_THREE_WIRE] ?
                   (fwd_latch_reg | rev_latch_reg) :
                   (filt_reg[0] | filt_reg[1]);
  assign o_run_forward = ctrl_reg[`CTRL_THREE_WIRE] ? fwd_latch_reg :
                         filt_reg[0];
  assign o_run_reverse = ctrl_reg[`CTRL_THREE_WIRE] ? rev_latch_reg :
                         filt_reg[1];
  assign o_gate_enable = !trip_reg;
  assign o_trip_message = trip_reg;
  assign o_stop_led_blink = trip_reg && blink_reg[`BLINK_BIT];

  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      fwd_latch_reg <= 1'b0;
      rev_latch_reg <= 1'b0;
      fx_prev_reg <= 1'b0;
      rx_prev_reg <= 1'b0;
      trip_reg <= 1'b0;
      blink_reg <= 22'h000000;
    end else begin
      fx_prev_reg <= filt_reg[0];
      rx_prev_reg <= filt_reg[1];
      blink_reg <= trip_reg ? blink_reg + 22'h000001 : 22'h000000;
      if (tripb_on) begin
        trip_reg <= 1'b1;
      end else if (trip_reset) begin
        trip_reg <= 1'b0;
      end
      if (trip_reg || tripb_on || !ctrl_reg[`CTRL_THREE_WIRE] ||
          !fval(fmap[`FN_STOP3W*3 +: 3], term_vec) &&
          fmap[`FN_STOP3W*3 +: 3] != 3'h0) begin
        fwd_latch_reg <= 1'b0;
        rev_latch_reg <= 1'b0;
      end else if (filt_reg[0] && !fx_prev_reg) begin
        fwd_latch_reg <= 1'b1;
        rev_latch_reg <= 1'b0;
      end else if (filt_reg[1] && !rx_prev_reg) begin
        rev_latch_reg <= 1'b1;
        fwd_latch_reg <= 1'b0;
      end
    end
  end

  // Speed command prohibit and process loop gate
  assign pid_en = (ctrl_reg[`CTRL_PID_HI:`CTRL_PID_LO] == `PID_ENABLE) ?
                  run_cmd :
                  (ctrl_reg[`CTRL_PID_HI:`CTRL_PID_LO] == `PID_TERMINAL) ?
                  (fmap[`FN_PID_DIS*3 +: 3] != 3'h0 &&
                   !fval(fmap[`FN_PID_DIS*3 +: 3], term_vec) &&
                   run_cmd) :
                  1'b0;
  assign o_pid_enable = pid_en;
  assign o_speed_cmd = speed_reg;
  assign o_pid_out = pid_reg;

  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      speed_reg <= 16'h0000;
      pid_reg <= 16'h0000;
    end else begin
      if (fwd_block && !i_speed_cmd[15] && i_speed_cmd != 16'h0000) begin
        speed_reg <= 16'h0000;
      end else if (rev_block && i_speed_cmd[15]) begin
        speed_reg <= 16'h0000;
      end else begin
        speed_reg <= i_speed_cmd;
      end
      pid_reg <= pid_en ? i_pid_out : 16'h0000;
    end
  end

  // Delay timer on tenth-second ticks
  assign tick = (tick_reg == TICK_LAST);
  assign on_delay = (timer_on_reg == 16'h0000) ? 16'h0001 : timer_on_reg;
  assign off_delay = (timer_off_reg == 16'h0000) ? 16'h0001 :
                     timer_off_reg;
  assign o_aux_output_one = timer_out_reg;

  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      tick_reg <= 20'h00000;
      timer_cnt_reg <= 16'h0000;
      timer_out_reg <= 1'b0;
    end else begin
      tick_reg <= tick ? 20'h00000 : tick_reg + 20'h00001;
      if (timer_in == timer_out_reg) begin
        timer_cnt_reg <= 16'h0000;
      end else if (tick) begin
        if (timer_cnt_reg + 16'h0001 >=
            (timer_in ? on_delay : off_delay)) begin
          timer_out_reg <= timer_in;
          timer_cnt_reg <= 16'h0000;
        end else begin
          timer_cnt_reg <= timer_cnt_reg + 16'h0001;
        end
      end
    end
  end

  // Ramp set selection
  assign o_ramp_bypass = fval(fmap[`FN_RAMP_BYPASS*3 +: 3], term_vec);
  assign o_accel_set = o_ramp_bypass ? 2'h0 :
                       {fval(fmap[`FN_XCEL_HI*3 +: 3], term_vec),
                        fval(fmap[`FN_XCEL_LO*3 +: 3], term_vec)};

  // Speed loop gain set, structure and proportional ramp
  assign gain_target = gain_set ? pgain_reg[21:11] : pgain_reg[10:0];
  assign o_gain_set = gain_set;
  assign o_gain_i = gain_set ? igain_reg[31:16] : igain_reg[15:0];
  assign o_gain_lpf = gain_set ? lpf_reg[31:16] : lpf_reg[15:0];
  assign o_gain_p = gain_p_reg;
  assign o_integral_en = !fval(fmap[`FN_STRUCT_SEL*3 +: 3], term_vec);
  assign ramp_full = ramp_reg * `RAMP_CYCLES_PER_MS_LSB;
  assign ramp_step = ramp_full[20:0];

  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      gain_p_reg <= 11'h000;
      ramp_cnt_reg <= 21'h000000;
      gain_set_prev_reg <= 1'b0;
    end else begin
      gain_set_prev_reg <= gain_set;
      if (gain_p_reg == gain_target) begin
        ramp_cnt_reg <= 21'h000000;
      end else if (ramp_cnt_reg + 21'h000001 >= ramp_step) begin
        ramp_cnt_reg <= 21'h000000;
        if (ramp_step == 21'h000000) begin
          gain_p_reg <= gain_target;
        end else if (gain_p_reg < gain_target) begin
          gain_p_reg <= gain_p_reg + 11'h001;
        end else begin
          gain_p_reg <= gain_p_reg - 11'h001;
        end
      end else begin
        ramp_cnt_reg <= ramp_cnt_reg + 21'h000001;
      end
    end
  end

  // Flux reference, analog scaled to tenths of a percent
  assign o_flux_from_analog = fval(fmap[`FN_FLUX_SEL*3 +: 3], term_vec);
  assign flux_prod = $signed(i_analog_in) * $signed({1'b0, `FLUX_SCALE});
  assign o_flux_ref = flux_out_reg;

  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      flux_out_reg <= 16'h0000;
    end else if (o_flux_from_analog) begin
      flux_out_reg <= flux_prod[26:11];
    end else begin
      flux_out_reg <= flux_reg;
    end
  end

  // Sticky interrupt status, write one to clear, set wins
  assign events = {gain_set != gain_set_prev_reg,
                   (tick && timer_in != timer_out_reg &&
                    timer_cnt_reg + 16'h0001 >=
                    (timer_in ? on_delay : off_delay)),
                   tripb_on && !trip_reg};
  assign o_irq = |(int_status_reg & int_mask_reg);

  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      int_status_reg <= 3'h0;
    end else if (do_write && awaddr_reg[5:2] == `INT_STATUS_ADDR >> 2 &&
                 wstrb_reg[0]) begin
      int_status_reg <= (int_status_reg & ~wdata_reg[2:0]) | events;
    end else begin
      int_status_reg <= int_status_reg | events;
    end
  end

endmodule

// ### verification/drive_input_function_logic_chk.sv
// Concurrent checks on the input decoder ports
`timescale 1ns/10ps
module drive_input_function_logic_chk (
  // Clock and reset
  input wire i_ref_clk,
  input wire i_rst,
  // Watched ports
  input wire [15:0] i_speed_cmd,
  input wire [15:0] i_pid_out,
  input wire i_bready,
  input wire i_rready,
  input wire o_bvalid,
  input wire [1:0] o_bresp,
  input wire o_rvalid,
  input wire [31:0] o_rdata,
  input wire o_run_forward,
  input wire o_run_reverse,
  input wire o_gate_enable,
  input wire o_trip_message,
  input wire o_stop_led_blink,
  input wire [15:0] o_speed_cmd,
  input wire o_pid_enable,
  input wire [15:0] o_pid_out,
  input wire [1:0] o_accel_set,
  input wire o_ramp_bypass
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  AST_TRIP_GATE: assert property (o_gate_enable != o_trip_message)
    else $error("gate enable does not follow trip");
  AST_BLINK: assert property (o_stop_led_blink |-> o_trip_message)
    else $error("stop lamp blinks without trip");
  AST_SPEED: assert property ((o_speed_cmd == $past(i_speed_cmd))
    || (o_speed_cmd == 16'h0000))
    else $error("speed command altered");
  AST_PID_OUT: assert property (o_pid_out != 16'h0000 |->
    $past(o_pid_enable) && o_pid_out == $past(i_pid_out))
    else $error("process output passed while disabled");
  AST_PID_RUN: assert property (o_pid_enable |->
    o_run_forward || o_run_reverse)
    else $error("process loop enabled without run");
  AST_ACCEL_BYP: assert property (o_ramp_bypass |-> o_accel_set == 2'h0)
    else $error("time set selected during bypass");
  AST_TRIP_HOLD: assert property ($fell(o_trip_message) |->
    o_bvalid || $past(o_bvalid))
    else $error("trip cleared without reset write");
  AST_B_HOLD: assert property (o_bvalid && !i_bready |=>
    o_bvalid && $stable(o_bresp))
    else $error("write response dropped");
  AST_R_HOLD: assert property (o_rvalid && !i_rready |=>
    o_rvalid && $stable(o_rdata))
    else $error("read data dropped");
  COV_TRIP: cover property ($rose(o_trip_message));
  COV_PID: cover property ($rose(o_pid_enable));
  COV_BYP: cover property ($rose(o_ramp_bypass));
endmodule

bind drive_input_function_logic drive_input_function_logic_chk i_chk (
  .i_ref_clk, .i_rst, .i_speed_cmd, .i_pid_out, .i_bready, .i_rready,
  .o_bvalid, .o_bresp, .o_rvalid, .o_rdata, .o_run_forward,
  .o_run_reverse, .o_gate_enable, .o_trip_message, .o_stop_led_blink,
  .o_speed_cmd, .o_pid_enable, .o_pid_out, .o_accel_set, .o_ramp_bypass
);

// ### verification/terminal_contacts.sv
// Contact bank model driving the run and function terminals
`timescale 1ns/10ps
module terminal_contacts (
  // Clock
  input wire i_ref_clk,
  // Requested contact states
  input wire i_fx_closed,
  input wire i_rx_closed,
  input wire [6:0] i_closed,
  // Terminal levels
  output reg o_fx,
  output reg o_rx,
  output reg [6:0] o_terminal
);
  initial begin
    o_fx = 1'b0;
    o_rx = 1'b0;
    o_terminal = 7'h00;
  end
  // Contacts move just after the clock edge
  always @(posedge i_ref_clk) begin
    o_fx <= i_fx_closed;
    o_rx <= i_rx_closed;
    o_terminal <= i_closed;
  end
endmodule

// ### verification/drive_input_function_logic_bench.sv
// Self-checking bench for the input decoder
`timescale 1ns/10ps
`include "drive_input_regs.vh"
module drive_input_function_logic_bench;
  logic i_ref_clk, i_rst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic [5:0] i_awaddr, i_araddr;
  logic [31:0] i_wdata, q;
  logic [3:0] i_wstrb;
  logic [15:0] i_speed_cmd, i_pid_out;
  logic [11:0] i_analog_in;
  logic fx_closed, rx_closed, fx, rx;
  logic [6:0] closed, term;
  logic [1:0] r, o_bresp, o_rresp, o_accel_set;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
  logic o_run_forward, o_run_reverse, o_gate_enable, o_trip_message;
  logic o_pid_enable, o_aux_output_one, o_ramp_bypass, o_gain_set;
  logic o_integral_en, o_flux_from_analog;
  logic [31:0] o_rdata;
  logic [15:0] o_speed_cmd, o_pid_out, o_flux_ref, o_gain_i, o_gain_lpf;
  logic [10:0] o_gain_p;
  int err_total, n_compared, n;
  localparam logic [4:0] PID_TBL [6] = '{5'h02, 5'h0B, 5'h08, 5'h13,
    5'h16, 5'h1A};

  terminal_contacts i_terminal_contacts (.i_ref_clk, .i_fx_closed(fx_closed),
    .i_rx_closed(rx_closed), .i_closed(closed), .o_fx(fx), .o_rx(rx),
    .o_terminal(term));
  drive_input_function_logic #(.TENTH_SEC_CYCLES(10))
    i_drive_input_function_logic (.*, .i_forward_run_input(fx),
    .i_reverse_run_input(rx), .i_terminal(term), .o_stop_led_blink());

  initial begin
    i_ref_clk = 1'b0;
    forever #50 i_ref_clk = ~i_ref_clk;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask

  task tick(input int k);
    repeat (k) @(posedge i_ref_clk);
  endtask

  task axi(input logic wr, input logic [5:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    int m;
    @(posedge i_ref_clk);
    m = 0;
    tb = 1'b0;
    if (wr) begin
      i_awaddr <= a;
      i_wdata <= d;
      i_awvalid <= 1'b1;
      i_wvalid <= 1'b1;
      i_bready <= 1'b1;
    end else begin
      i_araddr <= a;
      i_arvalid <= 1'b1;
      i_rready <= 1'b1;
    end
    while (!tb && m < 100) begin
      @(negedge i_ref_clk);
      m++;
      ta = wr ? i_awvalid & o_awready : i_arvalid & o_arready;
      tw = i_wvalid & o_wready;
      tb = wr ? o_bvalid : o_rvalid;
      q = o_rdata;
      r = wr ? o_bresp : o_rresp;
      @(posedge i_ref_clk);
      if (ta) begin
        i_awvalid <= 1'b0;
        i_arvalid <= 1'b0;
      end
      if (tw) i_wvalid <= 1'b0;
      if (tb) begin
        i_bready <= 1'b0;
        i_rready <= 1'b0;
      end
    end
    chk(tb, 1'b1);
  endtask

  task wr(input logic [5:0] a, input logic [31:0] d);
    axi(1'b1, a, d);
    chk(r, `RESP_OKAY);
  endtask

  task wait_aux(input logic lvl);
    n = 0;
    while (o_aux_output_one !== lvl && n < 80) begin
      tick(1);
      n++;
    end
  endtask

  task t_regs;
    axi(1'b0, `TIMER_ON_ADDR, 32'h0);
    chk(q, 32'h0000000A);
    axi(1'b0, 6'h38, 32'h0);
    chk(r, `RESP_SLVERR);
    wr(`TIMER_ON_ADDR, 32'h00000001);
    wr(`TIMER_OFF_ADDR, 32'h00000002);
    wr(`ASSIGN0_ADDR, 32'h00FAC688);
    wr(`ASSIGN1_ADDR, 32'h00000F35);
    wr(`INT_MASK_ADDR, 32'h00000001);
    axi(1'b0, `ASSIGN1_ADDR, 32'h0);
    chk(q, 32'h00000F35);
  endtask

  task t_trip;
    closed <= 7'h00;
    tick(12);
    chk(o_gate_enable, 1'b0);
    chk(o_trip_message, 1'b1);
    chk(o_irq, 1'b1);
    closed <= 7'h01;
    tick(12);
    chk(o_trip_message, 1'b1);
    wr(`CMD_ADDR, 32'h00000001);
    tick(2);
    chk(o_gate_enable, 1'b1);
    wr(`INT_MASK_ADDR, 32'h00000000);
    chk(o_irq, 1'b0);
    wr(`INT_STATUS_ADDR, 32'h00000007);
    wr(`INT_MASK_ADDR, 32'h00000001);
    chk(o_irq, 1'b0);
  endtask

  task t_speed;
    closed <= 7'h03;
    i_speed_cmd <= 16'h0064;
    tick(12);
    chk(o_speed_cmd, 16'h0000);
    i_speed_cmd <= 16'hFF9C;
    tick(2);
    chk(o_speed_cmd, 16'hFF9C);
    closed <= 7'h05;
    tick(12);
    chk(o_speed_cmd, 16'h0000);
    i_speed_cmd <= 16'h0064;
    tick(2);
    chk(o_speed_cmd, 16'h0064);
  endtask

  task t_pid;
    logic [4:0] v;
    i_pid_out <= 16'h1234;
    for (int k = 0; k < 6; k++) begin
      v = PID_TBL[k];
      wr(`CTRL_ADDR, {29'h0, v[4:3], 1'b0});
      closed <= {3'h0, v[2], 3'h1};
      fx_closed <= v[1];
      tick(12);
      chk(o_pid_enable, v[0]);
      chk(o_pid_out, v[0] ? 16'h1234 : 16'h0000);
      chk(o_integral_en, !v[2]);
    end
    fx_closed <= 1'b1;
  endtask

  task t_accel;
    i_analog_in <= 12'h800;
    for (int k = 0; k < 4; k++) begin
      closed <= {k[1], k[0], 5'h01};
      tick(12);
      chk(o_accel_set, k[1:0]);
      chk(o_gain_set, k[0]);
      chk(o_flux_from_analog, k[1]);
    end
    chk(o_flux_ref, 16'hFC18);
    closed <= 7'h71;
    wait_aux(1'b1);
    chk(n >= 5 && n <= 30, 1'b1);
    tick(2);
    chk(o_ramp_bypass, 1'b1);
    chk(o_accel_set, 2'h0);
    closed <= 7'h61;
    wait_aux(1'b0);
    chk(n >= 15 && n <= 40, 1'b1);
  endtask

  task t_gain;
    closed <= 7'h01;
    wr(`PGAIN_ADDR, 32'h00064064);
    wr(`RAMP_ADDR, 32'h00000001);
    wr(`IGAIN_ADDR, 32'h00020001);
    wr(`LPF_ADDR, 32'h00040003);
    tick(700);
    chk(o_gain_p, 11'h064);
    chk(o_gain_i, 16'h0001);
    chk(o_gain_lpf, 16'h0003);
    closed <= 7'h21;
    tick(60);
    chk(o_gain_p > 11'h064 && o_gain_p < 11'h0C8, 1'b1);
    tick(600);
    chk(o_gain_p, 11'h0C8);
    chk(o_gain_i, 16'h0002);
    chk(o_gain_lpf, 16'h0004);
  endtask

  task t_3wire;
    closed <= 7'h01;
    fx_closed <= 1'b0;
    wr(`CTRL_ADDR, 32'h00000001);
    tick(12);
    chk(o_run_forward, 1'b0);
    fx_closed <= 1'b1;
    tick(12);
    fx_closed <= 1'b0;
    tick(12);
    chk(o_run_forward, 1'b1);
    rx_closed <= 1'b1;
    tick(12);
    rx_closed <= 1'b0;
    tick(12);
    chk(o_run_reverse, 1'b1);
    wr(`CTRL_ADDR, 32'h00000000);
    tick(2);
    chk(o_run_forward | o_run_reverse, 1'b0);
  endtask

  task complete_run;
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    #3000000;
    err_total++;
    complete_run;
  end

  initial begin
    i_rst = 1'b1;
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h00;
    i_awaddr = 6'h00;
    i_araddr = 6'h00;
    i_wdata = 32'h0;
    i_wstrb = 4'hF;
    i_speed_cmd = 16'h0000;
    i_pid_out = 16'h0000;
    i_analog_in = 12'h000;
    fx_closed = 1'b1;
    rx_closed = 1'b0;
    closed = 7'h01;
    err_total = 0;
    n_compared = 0;
    tick(2);
    i_rst <= 1'b0;
    t_regs;
    t_trip;
    t_speed;
    t_pid;
    t_accel;
    t_gain;
    t_3wire;
    complete_run;
  end
endmodule
